/* File: rtl/pct_consts.svh */
// Purpose: offsets, field positions, reset values and counts of the interval counter
// Assumes: included by bare name
// Notes:   definitions only
`ifndef PCT_CONSTS_SVH
`define PCT_CONSTS_SVH
// Register byte addresses
`define PCT_ADDR_W      12
`define PCT_OFF_LOAD    12'h320
`define PCT_OFF_VALUE   12'h324
`define PCT_OFF_CTRL    12'h328
`define PCT_OFF_ICLR    12'h32c
`define PCT_OFF_CAP     12'h330
// Reset values
`define PCT_CTRL_RESET  32'h01000000
`define PCT_VALUE_RESET 32'hffffffff
`define PCT_CAP_RESET   32'h00000000
// Control field positions
`define PCT_PS_HI       31
`define PCT_PS_LO       24
`define PCT_PS_EN       23
`define PCT_CMP         19
`define PCT_ISRC        18
`define PCT_CAP_EN      17
`define PCT_EVT_HI      16
`define PCT_EVT_LO      12
`define PCT_SRC_HI      11
`define PCT_SRC_LO      9
`define PCT_UP          8
`define PCT_RUN         7
`define PCT_PERIODIC    6
`define PCT_FMT_HI      5
`define PCT_FMT_LO      4
`define PCT_PRE_HI      3
`define PCT_PRE_LO      0
// Event sources and prescaler codes with divide-minus-one limits
`define PCT_NUM_EVENTS  18
`define PCT_PRE_16      4'h4
`define PCT_PRE_256     4'h8
`define PCT_PRE_32K     4'hf
`define PCT_LIM_16      15'h000f
`define PCT_LIM_256     15'h00ff
`define PCT_LIM_32K     15'h7fff
// Time format limits
`define PCT_HUND_MAX    8'h63
`define PCT_MINSEC_MAX  8'h3b
`define PCT_HOUR23_MAX  8'h17
`define PCT_HOUR255_MAX 8'hff
// AXI responses
`define PCT_RESP_OKAY   2'b00
`define PCT_RESP_SLVERR 2'b10
`endif

/* File: rtl/pct_pkg.sv */
// Purpose: shared types of the interval counter
// Assumes: nothing
// Notes:   control word layout lives in pct_consts.svh
package pct_pkg;
  // Counting source choice
  typedef enum logic [2:0] {SRC_CORE, SRC_LPOSC, SRC_PIN8, SRC_PIN5} pct_src_t;
  // Count format choice
  typedef enum logic [1:0] {FMT_BIN, FMT_RSVD, FMT_T23, FMT_T255} pct_fmt_t;
  // Stored control fields
  typedef struct packed {
    logic       ps_en;
    logic       isrc_ps;
    logic       cap_en;
    logic [4:0] evt;
    pct_src_t   src;
    logic       up;
    logic       run;
    logic       periodic;
    pct_fmt_t   fmt;
    logic [3:0] pre;
  } pct_ctrl_t;
  // One counting step
  typedef struct packed {
    logic [31:0] value;
    logic        wrap;
  } pct_step_t;
endpackage

/* File: rtl/pct_tick_gen.sv */
// Purpose: source selection and prescaler, one-cycle count enable
// Assumes: lp_osc, pin8, pin5 synchronous levels
// Notes:   prescaler restarts while the counter is stopped
`timescale 1ns/1ps
`default_nettype none
`include "pct_consts.svh"
module pct_tick_gen
  import pct_pkg::*;
#(
  parameter int PRE_W = 15
) (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Settings
  input  wire logic       run,
  input  wire pct_src_t   src,
  input  wire logic [3:0] pre,
  // Source levels
  input  wire logic lp_osc,
  input  wire logic pin8,
  input  wire logic pin5,
  // Count enable
  output logic      tick
);
  if (PRE_W < 15) begin : g_chk
    $error("pct_tick_gen: PRE_W too small for divide by 32768");
  end

  logic [PRE_W-1:0] cnt_reg, cnt_next;
  logic [2:0]       prev_reg;
  logic             tick_reg, tick_next, pulse;

  // Divide-minus-one limit of a prescaler code
  function automatic logic [PRE_W-1:0] pre_limit(input logic [3:0] code);
    case (code)
      `PCT_PRE_16:  pre_limit = PRE_W'(`PCT_LIM_16);
      `PCT_PRE_256: pre_limit = PRE_W'(`PCT_LIM_256);
      `PCT_PRE_32K: pre_limit = PRE_W'(`PCT_LIM_32K);
      default:      pre_limit = '0;
    endcase
  endfunction

  // Source pulse, prescaler count
  always_comb begin
    case (src) // RULE_09
      SRC_CORE:  pulse = 1'b1;
      SRC_LPOSC: pulse = lp_osc & ~prev_reg[2];
      SRC_PIN8:  pulse = pin8 & ~prev_reg[1];
      SRC_PIN5:  pulse = pin5 & ~prev_reg[0];
      default:   pulse = 1'b0;
    endcase
    cnt_next  = cnt_reg;
    tick_next = 1'b0;
    if (!run) begin
      cnt_next = '0;
    end else if (pulse) begin
      if (cnt_reg >= pre_limit(pre)) begin // RULE_14
        cnt_next  = '0;
        tick_next = 1'b1;
      end else begin
        cnt_next = cnt_reg + PRE_W'(1);
      end
    end
  end

  // State registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg  <= '0;
      prev_reg <= 3'h0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      prev_reg <= {lp_osc, pin8, pin5};
      tick_reg <= tick_next;
    end
  end

  assign tick = tick_reg;
endmodule
`default_nettype wire

/* File: rtl/pct_time_step.sv */
// Purpose: next count value in binary or time format
// Assumes: time layout hours:minutes:seconds:hundredths, a byte each
// Notes:   purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "pct_consts.svh"
module pct_time_step
  import pct_pkg::*;
(
  // Present count and settings
  input  wire logic [31:0] value,
  input  wire logic        up,
  input  wire pct_fmt_t    fmt,
  // Next count and wrap
  output pct_step_t        step
);
  // One field step with carry or borrow
  function automatic logic [8:0] fstep(input logic [7:0] v, input logic [7:0] mx,
                                       input logic dir_up);
    if (dir_up) begin
      fstep = (v >= mx) ? 9'h100 : {1'b0, v + 8'h01};
    end else begin
      fstep = (v == 8'h00) ? {1'b1, mx} : {1'b0, v - 8'h01};
    end
  endfunction

  logic [8:0] h, s, m, hr;
  logic [7:0] hmax;

  // Field chain hundredths to hours
  always_comb begin
    hmax = (fmt == FMT_T23) ? `PCT_HOUR23_MAX : `PCT_HOUR255_MAX; // RULE_13
    h  = fstep(value[7:0], `PCT_HUND_MAX, up); // RULE_18
    s  = h[8] ? fstep(value[15:8], `PCT_MINSEC_MAX, up) : {1'b0, value[15:8]};
    m  = s[8] ? fstep(value[23:16], `PCT_MINSEC_MAX, up) : {1'b0, value[23:16]};
    hr = m[8] ? fstep(value[31:24], hmax, up) : {1'b0, value[31:24]};
    if (fmt == FMT_T23 || fmt == FMT_T255) begin
      step.value = {hr[7:0], m[7:0], s[7:0], h[7:0]};
      step.wrap  = hr[8];
    end else begin
      step.value = up ? value + 32'h1 : value - 32'h1; // RULE_10
      step.wrap  = up ? (value == 32'hffffffff) : (value == 32'h0);
    end
  end
endmodule
`default_nettype wire

/* File: rtl/pct_interval_counter.sv */
// Purpose: 32-bit interval counter with postscaler and event capture, AXI4-Lite slave
// Assumes: single clock aclk, synchronous active-low reset
// Notes:   answers a read one cycle after ar handshake, a write two after both taken
// Summary of operation
// RULE_01: Top control byte holds postscaler target; written zero means one.
// RULE_02: Reading top control byte returns the running postscaler count.
// RULE_03: Bit 23 set lets the postscaler count timeouts; cleared stops it.
// RULE_04: Software writes zeros to bits 22 to 20.
// RULE_05: Read-only bit 19 sets when overflow count equals postscaler target.
// RULE_06: Bit 18 picks interrupt from postscaler match or each timeout.
// RULE_07: Bit 17 enables event capture; cleared means no capture.
// RULE_08: Bits 16 to 12 choose which event source 0 to 17 captures.
// RULE_09: Bits 11 to 9 choose core clock, oscillator, pin eight or five.
// RULE_10: Bit 8 set counts up, cleared counts down, down after reset.
// RULE_11: Bit 7 starts and stops counting; stopped after reset.
// RULE_12: Bit 6 selects periodic when set, free-running when cleared.
// RULE_13: Bits 5 to 4 select binary, 23-hour or 255-hour time format.
// RULE_14: Bits 3 to 0 divide the source by 1, 16, 256 or 32768.
// RULE_15: First assertion of the chosen event copies the count; counting continues.
// RULE_16: Every overflow reloads the counter from the load register.
// RULE_17: Any write to the interrupt clear address drops the interrupt.
// RULE_18: Time format rolls hundredths at 100, seconds and minutes at 60.
`timescale 1ns/1ps
`default_nettype none
`include "pct_consts.svh"
module pct_interval_counter
  import pct_pkg::*;
#(
  parameter logic [31:0] LOAD_RESET = 32'h00000000,
  parameter int          NUM_EVENTS = `PCT_NUM_EVENTS
) (
  // Clock and reset
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // AXI4-Lite write channels
  input  wire logic [`PCT_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  // AXI4-Lite read channels
  input  wire logic [`PCT_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  // Counting sources
  input  wire logic                   lp_osc,
  input  wire logic                   pin8,
  input  wire logic                   pin5,
  // Capture events
  input  wire logic [NUM_EVENTS-1:0]  event_src,
  // Timer interrupt
  output logic                        irq
);
  if (NUM_EVENTS < 1 || NUM_EVENTS > 32) begin : g_chk
    $error("pct_interval_counter: NUM_EVENTS must be 1 to 32");
  end

  // Word address match
  function automatic logic is_reg(input logic [`PCT_ADDR_W-1:0] a,
                                  input logic [`PCT_ADDR_W-1:0] off);
    is_reg = (a[`PCT_ADDR_W-1:2] == off[`PCT_ADDR_W-1:2]);
  endfunction

  // Byte-lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      merge[8*i +: 8] = strb[i] ? nw[8*i +: 8] : old[8*i +: 8];
    end
  endfunction

  localparam pct_ctrl_t CTRL_RST = '0; // Fields clear; target of one kept apart

  // Counter state
  pct_ctrl_t   ctrl_reg, ctrl_next;
  logic [31:0] load_reg, load_next;
  logic [31:0] value_reg, value_next;
  logic [31:0] cap_reg, cap_next;
  logic [7:0]  ps_target_reg, ps_target_next;
  logic [7:0]  ps_count_reg, ps_count_next;
  logic        cmp_flag_reg, cmp_flag_next;
  logic        irq_reg, irq_next;
  logic        evt_prev_reg, evt_prev_next;
  // Bus state
  logic                   aw_held_reg, aw_held_next, w_held_reg, w_held_next;
  logic [`PCT_ADDR_W-1:0] awaddr_reg, awaddr_next;
  logic [31:0]            wdata_reg, wdata_next;
  logic [3:0]             wstrb_reg, wstrb_next;
  logic                   bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
  logic [1:0]             bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0]            rdata_reg, rdata_next;
  // Decoded events
  logic        tick, do_wr, wr_load, wr_ctrl, wr_iclr, timeout, ps_hit, irq_set;
  logic        evt_sel, evt_rise;
  logic [31:0] ctrl_word, wc;
  pct_step_t   step;

  pct_tick_gen #(
    .PRE_W (15)
  ) u_tick (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (ctrl_reg.run),
    .src     (ctrl_reg.src),
    .pre     (ctrl_reg.pre),
    .lp_osc  (lp_osc),
    .pin8    (pin8),
    .pin5    (pin5),
    .tick    (tick)
  );

  pct_time_step u_step (
    .value (value_reg),
    .up    (ctrl_reg.up),
    .fmt   (ctrl_reg.fmt),
    .step  (step)
  );

  // Control word view; reserved bits read zero
  assign ctrl_word = {ps_count_reg, ctrl_reg.ps_en, 3'b000, cmp_flag_reg, // RULE_02
                      ctrl_reg.isrc_ps, ctrl_reg.cap_en, ctrl_reg.evt, ctrl_reg.src,
                      ctrl_reg.up, ctrl_reg.run, ctrl_reg.periodic, ctrl_reg.fmt,
                      ctrl_reg.pre};
  assign wc = merge(ctrl_word, wdata_reg, wstrb_reg);

  // Write decode and counter events
  assign do_wr    = aw_held_reg & w_held_reg & ~bvalid_reg;
  assign wr_load  = do_wr & is_reg(awaddr_reg, `PCT_OFF_LOAD);
  assign wr_ctrl  = do_wr & is_reg(awaddr_reg, `PCT_OFF_CTRL);
  assign wr_iclr  = do_wr & is_reg(awaddr_reg, `PCT_OFF_ICLR);
  assign timeout  = tick & ctrl_reg.run & step.wrap;
  assign ps_hit   = timeout & ctrl_reg.ps_en & (ps_count_reg + 8'h01 == ps_target_reg);
  assign irq_set  = ctrl_reg.isrc_ps ? ps_hit : timeout; // RULE_06
  assign evt_sel  = (32'(ctrl_reg.evt) < NUM_EVENTS) ? event_src[ctrl_reg.evt] : 1'b0;
  assign evt_rise = evt_sel & ~evt_prev_reg;

  // Next values of the counter state
  always_comb begin
    ctrl_next      = ctrl_reg;
    load_next      = load_reg;
    value_next     = value_reg;
    cap_next       = cap_reg;
    ps_target_next = ps_target_reg;
    ps_count_next  = ps_count_reg;
    evt_prev_next  = evt_sel;
    // Control write, reserved and flag bits not stored
    if (wr_ctrl) begin
      ctrl_next.ps_en    = wc[`PCT_PS_EN];
      ctrl_next.isrc_ps  = wc[`PCT_ISRC];
      ctrl_next.cap_en   = wc[`PCT_CAP_EN];
      ctrl_next.evt      = wc[`PCT_EVT_HI:`PCT_EVT_LO];
      ctrl_next.src      = pct_src_t'(wc[`PCT_SRC_HI:`PCT_SRC_LO]);
      ctrl_next.up       = wc[`PCT_UP];
      ctrl_next.run      = wc[`PCT_RUN];
      ctrl_next.periodic = wc[`PCT_PERIODIC];
      ctrl_next.fmt      = pct_fmt_t'(wc[`PCT_FMT_HI:`PCT_FMT_LO]);
      ctrl_next.pre      = wc[`PCT_PRE_HI:`PCT_PRE_LO];
    end
    if (wr_load) begin
      load_next = merge(load_reg, wdata_reg, wstrb_reg);
    end
    // Counting; periodic mode also restarts on a load write
    if (wr_load && ctrl_reg.periodic) begin // RULE_12
      value_next = load_next;
    end else if (timeout) begin
      value_next = load_reg; // RULE_16
    end else if (tick && ctrl_reg.run) begin // RULE_11
      value_next = step.value;
    end
    // Postscaler
    if (wr_ctrl && wstrb_reg[3]) begin
      ps_target_next = (wdata_reg[`PCT_PS_HI:`PCT_PS_LO] == 8'h00) ? 8'h01 // RULE_01
                       : wdata_reg[`PCT_PS_HI:`PCT_PS_LO];
      ps_count_next  = 8'h00;
    end else if (ps_hit) begin
      ps_count_next = 8'h00;
    end else if (timeout && ctrl_reg.ps_en) begin // RULE_03
      ps_count_next = ps_count_reg + 8'h01;
    end
    // Capture on first assertion of the chosen event
    if (ctrl_reg.cap_en && evt_rise) begin // RULE_07 RULE_08
      cap_next = value_reg; // RULE_15
    end
  end

  // Sticky flags, set wins over clear
  always_comb begin
    cmp_flag_next = ps_hit | (cmp_flag_reg & ~wr_iclr); // RULE_05
    irq_next      = irq_set | (irq_reg & ~wr_iclr); // RULE_17
  end

  // Counter registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_reg      <= CTRL_RST;
      load_reg      <= LOAD_RESET;
      value_reg     <= `PCT_VALUE_RESET;
      cap_reg       <= `PCT_CAP_RESET;
      ps_target_reg <= 8'h01;
      ps_count_reg  <= 8'h00;
      cmp_flag_reg  <= 1'b0;
      irq_reg       <= 1'b0;
      evt_prev_reg  <= 1'b0;
    end else begin
      ctrl_reg      <= ctrl_next;
      load_reg      <= load_next;
      value_reg     <= value_next;
      cap_reg       <= cap_next;
      ps_target_reg <= ps_target_next;
      ps_count_reg  <= ps_count_next;
      cmp_flag_reg  <= cmp_flag_next;
      irq_reg       <= irq_next;
      evt_prev_reg  <= evt_prev_next;
    end
  end

  // Bus slave next values
  always_comb begin
    aw_held_next = aw_held_reg;
    awaddr_next  = awaddr_reg;
    w_held_next  = w_held_reg;
    wdata_next   = wdata_reg;
    wstrb_next   = wstrb_reg;
    bvalid_next  = bvalid_reg & ~s_axi_bready;
    bresp_next   = bresp_reg;
    rvalid_next  = rvalid_reg & ~s_axi_rready;
    rresp_next   = rresp_reg;
    rdata_next   = rdata_reg;
    if (s_axi_awvalid && !aw_held_reg) begin
      aw_held_next = 1'b1;
      awaddr_next  = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_held_reg) begin
      w_held_next = 1'b1;
      wdata_next  = s_axi_wdata;
      wstrb_next  = s_axi_wstrb;
    end
    if (do_wr) begin
      aw_held_next = 1'b0;
      w_held_next  = 1'b0;
      bvalid_next  = 1'b1;
      if (is_reg(awaddr_reg, `PCT_OFF_LOAD) || is_reg(awaddr_reg, `PCT_OFF_VALUE) ||
          is_reg(awaddr_reg, `PCT_OFF_CTRL) || is_reg(awaddr_reg, `PCT_OFF_ICLR) ||
          is_reg(awaddr_reg, `PCT_OFF_CAP)) begin
        bresp_next = `PCT_RESP_OKAY;
      end else begin
        bresp_next = `PCT_RESP_SLVERR;
      end
    end
    if (s_axi_arvalid && !rvalid_reg) begin
      rvalid_next = 1'b1;
      rresp_next  = `PCT_RESP_OKAY;
      if (is_reg(s_axi_araddr, `PCT_OFF_LOAD)) begin
        rdata_next = load_reg;
      end else if (is_reg(s_axi_araddr, `PCT_OFF_VALUE)) begin
        rdata_next = value_reg;
      end else if (is_reg(s_axi_araddr, `PCT_OFF_CTRL)) begin
        rdata_next = ctrl_word;
      end else if (is_reg(s_axi_araddr, `PCT_OFF_CAP)) begin
        rdata_next = cap_reg;
      end else if (is_reg(s_axi_araddr, `PCT_OFF_ICLR)) begin
        rdata_next = 32'h00000000;
      end else begin
        rdata_next = 32'h00000000;
        rresp_next = `PCT_RESP_SLVERR;
      end
    end
  end

  // Bus slave registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      awaddr_reg  <= '0;
      w_held_reg  <= 1'b0;
      wdata_reg   <= 32'h00000000;
      wstrb_reg   <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= `PCT_RESP_OKAY;
      rvalid_reg  <= 1'b0;
      rresp_reg   <= `PCT_RESP_OKAY;
      rdata_reg   <= 32'h00000000;
    end else begin
      aw_held_reg <= aw_held_next;
      awaddr_reg  <= awaddr_next;
      w_held_reg  <= w_held_next;
      wdata_reg   <= wdata_next;
      wstrb_reg   <= wstrb_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      rvalid_reg  <= rvalid_next;
      rresp_reg   <= rresp_next;
      rdata_reg   <= rdata_next;
    end
  end

  // Port drive
  assign s_axi_awready = ~aw_held_reg;
  assign s_axi_wready  = ~w_held_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = ~rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rresp   = rresp_reg;
  assign s_axi_rdata   = rdata_reg;
  assign irq           = irq_reg;

  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_rd_ctrl;
    s_axi_arvalid && s_axi_arready && is_reg(s_axi_araddr, `PCT_OFF_CTRL);
  endsequence
  sequence s_ps_zero;
    wr_ctrl && wstrb_reg[3] && wdata_reg[31:24] == 8'h00;
  endsequence

  property p_ps_zero;
    s_ps_zero |=> ps_target_reg == 8'h01 ##1 ps_count_reg == 8'h00 || timeout;
  endproperty
  a_ps_zero: assert property (p_ps_zero) else $error("zero target not one"); // RULE_01

  property p_rd_count;
    s_rd_ctrl |=> s_axi_rvalid && s_axi_rdata[31:24] == $past(ps_count_reg);
  endproperty
  a_rd_count: assert property (p_rd_count) else $error("top byte not count"); // RULE_02

  property p_ps_idle;
    !ctrl_reg.ps_en && !wr_ctrl |=> $stable(ps_count_reg);
  endproperty
  a_ps_idle: assert property (p_ps_idle) else $error("postscaler moved"); // RULE_03

  property p_cmp;
    ps_hit |=> cmp_flag_reg && ps_count_reg == 8'h00;
  endproperty
  a_cmp: assert property (p_cmp) else $error("compare flag missed"); // RULE_05

  property p_irq_src;
    timeout && !ctrl_reg.isrc_ps |=> irq;
  endproperty
  a_irq_src: assert property (p_irq_src) else $error("timeout irq missed"); // RULE_06

  property p_no_cap;
    !ctrl_reg.cap_en |=> $stable(cap_reg);
  endproperty
  a_no_cap: assert property (p_no_cap) else $error("capture while off"); // RULE_07

  property p_cap;
    ctrl_reg.cap_en && evt_rise |=> cap_reg == $past(value_reg);
  endproperty
  a_cap: assert property (p_cap) else $error("capture value wrong"); // RULE_15

  property p_stop;
    !ctrl_reg.run && !wr_load |=> $stable(value_reg);
  endproperty
  a_stop: assert property (p_stop) else $error("counter ran while stopped"); // RULE_11

  property p_reload;
    timeout && !wr_load |=> value_reg == $past(load_reg);
  endproperty
  a_reload: assert property (p_reload) else $error("no reload on overflow"); // RULE_16

  property p_clear;
    wr_iclr && !irq_set ##1 !irq_set |=> !irq;
  endproperty
  a_clear: assert property (p_clear) else $error("irq not cleared"); // RULE_17

  property p_up;
    tick && ctrl_reg.run && ctrl_reg.up && ctrl_reg.fmt == FMT_BIN && !step.wrap
      && !wr_load |=> value_reg == $past(value_reg) + 32'h1;
  endproperty
  a_up: assert property (p_up) else $error("up count wrong"); // RULE_10
endmodule
`default_nettype wire

/* File: dv/tb_pct_interval_counter.sv */
// Purpose: self-checking bench of the interval counter over AXI4-Lite
// Assumes: 25 MHz aclk, synchronous active-low reset, core clock and pin five sources
// Notes:   expected values come from the queues below, literals and earlier value register reads
`timescale 1ns/1ps
`default_nettype none
`include "pct_consts.svh"
module tb_pct_interval_counter import pct_pkg::*;;
  localparam logic [11:0] A_LD = `PCT_OFF_LOAD, A_CT = `PCT_OFF_CTRL, A_IC = `PCT_OFF_ICLR;
  logic        aclk = 1'b0, aresetn = 1'b0, irq;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        lp_osc = 1'b0, pin8 = 1'b0, pin5 = 1'b0;
  logic [17:0] event_src = 18'h0;
  logic [7:0]  rnd = 8'h52;
  logic [2:0]  pin_mask = 3'h7;
  logic        p5_q = 1'b0;
  int          miscompares = 0, n_compared = 0, cycles = 0, n5 = 0;
  // Reference model: register map at reset and postscaler cases
  logic [11:0] adr_q[$] = '{12'h320, 12'h324, 12'h328, 12'h32c, 12'h330};
  logic [31:0] rst_q[$] = '{32'h0, 32'hffffffff, 32'h0, 32'h0, 32'h0};
  logic [7:0]  tgt_q[$] = '{8'h00, 8'h02, 8'h03};
  logic [7:0]  cnt_q[$] = '{8'h00, 8'h00, 8'h01};
  logic        isr_q[$] = '{1'b1, 1'b1, 1'b0};
  int          n_q[$]   = '{1, 2, 1};

  pct_interval_counter dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .lp_osc, .pin8, .pin5, .event_src, .irq);

  // Clock
  always #20 aclk = ~aclk;

  function automatic logic [7:0] lfsr(input logic [7:0] x);
    return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
  endfunction

  // Random source levels and run limit
  always @(posedge aclk) begin
    rnd <= lfsr(rnd);
    {lp_osc, pin8, pin5} <= rnd[2:0] & pin_mask;
    // Model of the pin five edge count
    p5_q <= pin5;
    if (pin5 && !p5_q) n5 <= n5 + 1;
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      miscompares++;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("compared=%0d miscompares=%0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Write: address and data offered together, each released when taken
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    logic ta, tw;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(negedge aclk);
      ta = s_axi_awvalid & s_axi_awready;
      tw = s_axi_wvalid & s_axi_wready;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end while ((s_axi_awvalid & !ta) | (s_axi_wvalid & !tw));
    do @(negedge aclk); while (!s_axi_bvalid);
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge aclk); while (!s_axi_arready);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask

  task automatic pulse(input logic [17:0] m);
    @(posedge aclk);
    event_src <= m;
    repeat (2) @(posedge aclk);
    event_src <= 18'h0;
  endtask

  // Main sequence
  initial begin
    logic [31:0] d, v, cfg;
    logic [1:0]  r;
    int          e;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    foreach (adr_q[i]) begin
      rd(adr_q[i], d, r);
      chk(d, rst_q[i]);
    end
    rd(12'h334, d, r);
    chk({30'h0, r}, {30'h0, `PCT_RESP_SLVERR});
    v = {4{rnd}};
    wr(A_LD, v, 4'hf);
    rd(A_LD, d, r);
    chk(d, v);
    // Postscaler target, interrupt origin, compare flag and clear
    foreach (tgt_q[i]) begin
      cfg = {tgt_q[i], 5'h10, isr_q[i], 2'h0, 16'h00c0};
      wr(A_CT, cfg ^ 32'h80, 4'hf);
      wr(A_LD, 32'hb, 4'hf);
      wr(A_IC, 32'h0, 4'hf);
      wr(A_CT, cfg, 4'hf);
      repeat (12 * n_q[i] - 3) @(negedge aclk);
      chk({31'h0, irq}, 32'h0);
      repeat (7) @(negedge aclk);
      chk({31'h0, irq}, 32'h1);
      wr(A_CT, cfg ^ 32'h80, 4'h7);
      rd(A_CT, d, r);
      chk(d, {cnt_q[i], 4'h8, isr_q[i], isr_q[i], 18'h00040});
      wr(A_IC, {24'h0, rnd}, 4'hf);
      @(negedge aclk);
      chk({31'h0, irq}, 32'h0);
    end
    // Event capture with the counter stopped
    rd(`PCT_OFF_VALUE, v, r);
    e = int'(rnd) % 18;
    wr(A_CT, {15'h0, e[4:0], 12'h0}, 4'hf);
    pulse(18'h1 << e);
    rd(`PCT_OFF_CAP, d, r);
    chk(d, 32'h0);
    wr(A_CT, {14'h0, 1'b1, e[4:0], 12'h0}, 4'hf);
    pulse(~(18'h1 << e));
    rd(`PCT_OFF_CAP, d, r);
    chk(d, 32'h0);
    pulse(18'h1 << e);
    rd(`PCT_OFF_CAP, d, r);
    chk(d, v);
    // Pin five source counting up; pins quiet around start and stop
    pin_mask <= 3'h0;
    rd(`PCT_OFF_VALUE, v, r);
    e = n5;
    wr(A_CT, 32'h00000780, 4'hf);
    pin_mask <= 3'h1;
    repeat (40) @(posedge aclk);
    pin_mask <= 3'h0;
    repeat (3) @(posedge aclk);
    e = n5 - e;
    wr(A_CT, 32'h00000700, 4'hf);
    rd(`PCT_OFF_VALUE, d, r);
    chk(d, v + 32'(e));
    // Time format up count across a minute, core clock divided by 16
    wr(A_CT, 32'h00000164, 4'hf);
    wr(A_LD, 32'h00013b63, 4'hf);
    wr(A_CT, 32'h000001e4, 4'hf);
    repeat (16) @(posedge aclk);
    rd(`PCT_OFF_VALUE, d, r);
    chk(d, 32'h00020000);
    complete_run();
  end
endmodule
`default_nettype wire
